//--- hw/dcc_top.sv
// dual capture/compare array: two units, four time bases, 32 channels, APB registers
`timescale 1ns/100ps
module dcc_top #(
  parameter int UNITS = 2,
  parameter int CH_PER_UNIT = 16,
  parameter int TIMER_WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_gpt_ovf,
  input wire logic [1:0] i_ext_count,
  input wire logic [31:0] i_ch_pin,
  output logic [31:0] o_ch_pin,
  output logic [31:0] o_ch_oe,
  output logic o_irq
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // the map and the pin vectors are laid out for exactly this shape
  // the register map, the 32-bit pin and status vectors and the timer
  // select arithmetic below all assume two units of sixteen channels;
  // other shapes would need a new map, so they are refused here rather
  // than silently truncated
  if (UNITS != 2 || CH_PER_UNIT != 16 || TIMER_WIDTH != 16) begin : g_bad_shape
    $error("dcc_top supports only two units of 16 channels with 16-bit timers");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // every flip-flop of the block lives in this one record so that reset,
  // clock enable and the next-state copy treat all of it alike
  // presc: free-running divider shared by all four time bases
  // tctl/tcnt/trel: per timer control, count and reload, index 2*unit+timer
  // cmode/cval: per channel mode and capture/compare value, index 16*unit+ch
  // done: once-per-period latch of compare modes 2 and 3
  typedef struct packed {
    logic [9:0] presc;
    logic [3:0][5:0] tctl;
    logic [3:0][15:0] tcnt;
    logic [3:0][15:0] trel;
    logic [1:0] ext_prev;
    logic [31:0][4:0] cmode;
    logic [31:0][15:0] cval;
    logic [31:0] pin_prev;
    logic [31:0] done;
    logic [31:0] pin_out;
    logic [31:0] oe;
    logic [31:0] ch_stat;
    logic [31:0] ch_en;
    logic [3:0] t_stat;
    logic [3:0] t_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } dcc_state_type;

  dcc_state_type state_ff;
  dcc_state_type nxt_state;

  // bus decode helpers
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rdata;
  // per timer events of this cycle
  logic [3:0] tick;
  logic [3:0] upd;
  logic [3:0] ovf;
  logic [9:0] mask;
  // status set and clear requests
  logic [31:0] ch_set;
  logic [31:0] ch_clr;
  logic [3:0] t_clr;
  // per channel pin edges and compare hits
  logic [31:0] rise;
  logic [31:0] fall;
  logic [31:0] match;
  // loop scratch, given a value at the top of the process
  logic [11:0] base;
  logic [1:0] tsel;
  logic [3:0] mode;
  logic [4:0] part;
  logic pmatch;
  logic [1:0] ext_rise;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // write lands at the edge where pready is seen high with psel and penable
  // the read decode is taken in the first access cycle, so the answer is
  // registered and o_pready rises one cycle later; a write waits for that
  // same edge so that the bus sees a single point of effect either way
  assign wr_en = i_psel & i_penable & state_ff.pready & i_pwrite;
  assign rd_en = i_psel & i_penable & ~state_ff.pready;

  always_comb begin
    nxt_state = state_ff;
    rdata = 32'h0000_0000;
    hit = 1'b0;
    ch_set = 32'h0000_0000;
    ch_clr = 32'h0000_0000;
    t_clr = 4'h0;
    tick = 4'h0;
    upd = 4'h0;
    ovf = 4'h0;
    mask = 10'h000;
    match = 32'h0000_0000;
    base = 12'h000;
    tsel = 2'h0;
    mode = dcc_pkg::MODE_OFF;
    part = 5'h00;
    pmatch = 1'b0;

    // free-running prescaler shared by all four time bases
    // one shared counter keeps the dividers of all timers in phase with
    // each other; a timer started mid-count may see its first tick early
    // by up to one divided period, which software must allow for
    nxt_state.presc = state_ff.presc + 10'h001;
    ext_rise = i_ext_count & ~state_ff.ext_prev;
    nxt_state.ext_prev = i_ext_count;
    // pin history clears to low, so a pin already high at reset release
    // reads as one rising edge on its first sampled cycle
    rise = i_ch_pin & ~state_ff.pin_prev;
    fall = ~i_ch_pin & state_ff.pin_prev;
    nxt_state.pin_prev = i_ch_pin;

    // register decode: reads and writes of the per-unit blocks
    // both units share one layout at a stride of one page; unit u owns
    // timers 2u and 2u+1 and channels 16u to 16u+15
    for (int u = 0; u < 2; u++) begin
      base = 12'(u) * dcc_pkg::UNIT_STRIDE;
      for (int b = 0; b < 2; b++) begin
        if (i_paddr == base + dcc_pkg::OFS_TCTL + 12'(4 * b)) begin
          hit = 1'b1;
          rdata = {26'h0, state_ff.tctl[2 * u + b]};
          if (wr_en) nxt_state.tctl[2 * u + b] = i_pwdata[5:0];
        end
        if (i_paddr == base + dcc_pkg::OFS_TCNT + 12'(4 * b)) begin
          hit = 1'b1;
          rdata = {16'h0, state_ff.tcnt[2 * u + b]};
          if (wr_en) nxt_state.tcnt[2 * u + b] = i_pwdata[15:0];
        end
        if (i_paddr == base + dcc_pkg::OFS_TREL + 12'(4 * b)) begin
          hit = 1'b1;
          rdata = {16'h0, state_ff.trel[2 * u + b]};
          if (wr_en) nxt_state.trel[2 * u + b] = i_pwdata[15:0];
        end
      end
      for (int k = 0; k < 16; k++) begin
        if (i_paddr == base + dcc_pkg::OFS_CMODE + 12'(4 * k)) begin
          hit = 1'b1;
          rdata = {27'h0, state_ff.cmode[16 * u + k]};
          if (wr_en) nxt_state.cmode[16 * u + k] = i_pwdata[4:0];
        end
        if (i_paddr == base + dcc_pkg::OFS_CVAL + 12'(4 * k)) begin
          hit = 1'b1;
          rdata = {16'h0, state_ff.cval[16 * u + k]};
          if (wr_en) nxt_state.cval[16 * u + k] = i_pwdata[15:0];
        end
      end
    end

    // interrupt block registers; clear registers read as zero
    // the status registers are read-only: a write there is accepted on the
    // bus but changes nothing, only the clear registers take bits away
    case (i_paddr)
      dcc_pkg::OFS_CH_STAT: begin
        hit = 1'b1;
        rdata = state_ff.ch_stat;
      end
      dcc_pkg::OFS_CH_CLR: begin
        hit = 1'b1;
        if (wr_en) ch_clr = i_pwdata;
      end
      dcc_pkg::OFS_CH_EN: begin
        hit = 1'b1;
        rdata = state_ff.ch_en;
        if (wr_en) nxt_state.ch_en = i_pwdata;
      end
      dcc_pkg::OFS_T_STAT: begin
        hit = 1'b1;
        rdata = {28'h0, state_ff.t_stat};
      end
      dcc_pkg::OFS_T_CLR: begin
        hit = 1'b1;
        if (wr_en) t_clr = i_pwdata[3:0];
      end
      dcc_pkg::OFS_T_EN: begin
        hit = 1'b1;
        rdata = {28'h0, state_ff.t_en};
        if (wr_en) nxt_state.t_en = i_pwdata[3:0];
      end
      default: begin
        hit = hit;
      end
    endcase

    // time bases: a timer count update wins over a software write in the same cycle
    // a cleared run bit freezes the count but not the shared prescaler;
    // the external source exists on timer a only, so code 2 stops timer b
    // overflow is taken at FFFFh before the reload, so the interrupt flag,
    // the compare re-arm and the mode 3 pin clear all see the same edge
    for (int t = 0; t < 4; t++) begin
      // code n divides by 2^(n+3): mask of n+3 low ones
      mask = 10'h3FF >> (3'h7 - state_ff.tctl[t][dcc_pkg::TCTL_SEL_LSB +: 3]);
      case (state_ff.tctl[t][dcc_pkg::TCTL_SRC_LSB +: 2])
        dcc_pkg::SRC_PRESC: tick[t] = (state_ff.presc & mask) == mask;
        dcc_pkg::SRC_GPT: tick[t] = i_gpt_ovf;
        dcc_pkg::SRC_EXT: tick[t] = (t % 2 == 0) ? ext_rise[t / 2] : 1'b0;
        default: tick[t] = 1'b0;
      endcase
      if (state_ff.tctl[t][dcc_pkg::TCTL_RUN_BIT] && tick[t]) begin
        upd[t] = 1'b1;
        if (state_ff.tcnt[t] == dcc_pkg::TIMER_MAX) begin
          // reload zero restarts at 0000h: a full 65536-tick period
          nxt_state.tcnt[t] = state_ff.trel[t];
          ovf[t] = 1'b1;
        end else begin
          nxt_state.tcnt[t] = state_ff.tcnt[t] + 16'h0001;
        end
      end
    end

    // channels: the compare sees the value the timer has just taken
    // the compare runs only on an update of the allocated timer, so a
    // stopped timer never repeats a match; writing the count to the
    // compare value by software does not trigger one either
    // capture takes the count before this edge's update, matching what
    // software would have read in the same cycle
    for (int c = 0; c < 32; c++) begin
      tsel = 2'((c / 16) * 2) | {1'b0, state_ff.cmode[c][dcc_pkg::CMODE_TSEL_BIT]};
      match[c] = upd[tsel] && (nxt_state.tcnt[tsel] == state_ff.cval[c]);
    end
    for (int c = 0; c < 32; c++) begin
      tsel = 2'((c / 16) * 2) | {1'b0, state_ff.cmode[c][dcc_pkg::CMODE_TSEL_BIT]};
      mode = state_ff.cmode[c][3:0];
      // a new period re-arms the once-per-period modes
      if (ovf[tsel]) nxt_state.done[c] = 1'b0;
      nxt_state.oe[c] = 1'b0;
      case (mode)
        // capture: the pin is only an input here, its output enable stays low
        dcc_pkg::MODE_CAP_RISE, dcc_pkg::MODE_CAP_FALL, dcc_pkg::MODE_CAP_BOTH: begin
          if ((rise[c] && mode != dcc_pkg::MODE_CAP_FALL) ||
              (fall[c] && mode != dcc_pkg::MODE_CAP_RISE)) begin
            // capture overrides a software write to the same register
            nxt_state.cval[c] = state_ff.tcnt[tsel];
            ch_set[c] = 1'b1;
          end
        end
        // mode 0: status only, the pin stays released
        dcc_pkg::MODE_CMP0: begin
          if (match[c]) ch_set[c] = 1'b1;
        end
        // mode 1: the channel drives its pin and flips it on every hit
        dcc_pkg::MODE_CMP1: begin
          nxt_state.oe[c] = 1'b1;
          if (match[c]) begin
            nxt_state.pin_out[c] = ~state_ff.pin_out[c];
            ch_set[c] = 1'b1;
          end
        end
        // mode 2: the done latch blocks further interrupts until the
        // allocated timer next overflows
        dcc_pkg::MODE_CMP2: begin
          if (match[c] && (state_ff.done[c] == 1'b0 || ovf[tsel])) begin
            ch_set[c] = 1'b1;
            nxt_state.done[c] = 1'b1;
          end
        end
        // mode 3: overflow clears first, so a match on the reload value itself
        // still sets the pin at the start of the new period
        dcc_pkg::MODE_CMP3: begin
          nxt_state.oe[c] = 1'b1;
          if (ovf[tsel]) nxt_state.pin_out[c] = 1'b0;
          if (match[c] && (state_ff.done[c] == 1'b0 || ovf[tsel])) begin
            nxt_state.pin_out[c] = 1'b1;
            ch_set[c] = 1'b1;
            nxt_state.done[c] = 1'b1;
          end
        end
        dcc_pkg::MODE_DOUBLE: begin
          // only the lower eight of a unit pair with channel+8; that partner's pin stays free
          if (c % 16 < 8) begin
            part = 5'(c + 8);
            pmatch = match[part];
            nxt_state.oe[c] = 1'b1;
            if (match[c] ^ pmatch) nxt_state.pin_out[c] = ~state_ff.pin_out[c];
            if (match[c]) ch_set[c] = 1'b1;
            if (pmatch) ch_set[part] = 1'b1;
          end
        end
        default: begin
          nxt_state.oe[c] = 1'b0;
        end
      endcase
    end

    // sticky flags: a hardware set wins over a clear in the same cycle
    // the interrupt line is registered from the next status and enable,
    // so it moves at the same edge as the flag that causes it
    nxt_state.ch_stat = (state_ff.ch_stat & ~ch_clr) | ch_set;
    nxt_state.t_stat = (state_ff.t_stat & ~t_clr) | ovf;
    nxt_state.irq = |(nxt_state.ch_stat & nxt_state.ch_en) | |(nxt_state.t_stat & nxt_state.t_en);

    // apb: one wait cycle, answer registered, error on unmapped address
    // a write to an unmapped address is answered with an error and dropped;
    // read data of a write transfer is driven as zero
    nxt_state.pready = rd_en;
    if (rd_en) begin
      nxt_state.prdata = i_pwrite ? 32'h0000_0000 : rdata;
      nxt_state.pslverr = ~hit;
    end else begin
      nxt_state.pslverr = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // synchronous reset to all zero; clock enable low freezes everything
  // reset is honoured even with the clock enable low, so a frozen block can
  // still be brought to a known state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_ff <= '0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a plain copy of a state flip-flop, so no decode logic
  // reaches a pin or the bus directly
  assign o_prdata = state_ff.prdata;
  assign o_pready = state_ff.pready;
  assign o_pslverr = state_ff.pslverr;
  assign o_ch_pin = state_ff.pin_out;
  assign o_ch_oe = state_ff.oe;
  assign o_irq = state_ff.irq;

endmodule

//--- hw/dcc_pkg.sv
// package: register map, field layout and mode codes of the dual capture/compare array
package dcc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------
  localparam logic [11:0] UNIT_STRIDE = 12'h100;
  localparam logic [11:0] OFS_TCTL = 12'h000;  // + 4 * timer (a=0, b=1)
  localparam logic [11:0] OFS_TCNT = 12'h008;
  localparam logic [11:0] OFS_TREL = 12'h010;
  localparam logic [11:0] OFS_CMODE = 12'h040;  // + 4 * channel
  localparam logic [11:0] OFS_CVAL = 12'h080;  // + 4 * channel
  localparam logic [11:0] OFS_CH_STAT = 12'h200;
  localparam logic [11:0] OFS_CH_CLR = 12'h204;
  localparam logic [11:0] OFS_CH_EN = 12'h208;
  localparam logic [11:0] OFS_T_STAT = 12'h20C;
  localparam logic [11:0] OFS_T_CLR = 12'h210;
  localparam logic [11:0] OFS_T_EN = 12'h214;

  // ------------------------------------------------------------
  // timer control fields
  // ------------------------------------------------------------
  localparam int TCTL_SEL_LSB = 0;  // 3-bit timer_input_select
  localparam int TCTL_SRC_LSB = 3;  // 2-bit clock source
  localparam int TCTL_RUN_BIT = 5;
  localparam logic [1:0] SRC_PRESC = 2'h0;
  localparam logic [1:0] SRC_GPT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam int PRESC_MIN_LOG2 = 3;  // code 000b divides by 8
  localparam int PRESC_WIDTH = 10;  // code 111b divides by 1024

  // ------------------------------------------------------------
  // channel mode field: [3:0] mode, [4] timer b allocated
  // ------------------------------------------------------------
  localparam int CMODE_TSEL_BIT = 4;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_RISE = 4'h1;
  localparam logic [3:0] MODE_CAP_FALL = 4'h2;
  localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
  localparam logic [3:0] MODE_CMP0 = 4'h4;
  localparam logic [3:0] MODE_CMP1 = 4'h5;
  localparam logic [3:0] MODE_CMP2 = 4'h6;
  localparam logic [3:0] MODE_CMP3 = 4'h7;
  localparam logic [3:0] MODE_DOUBLE = 4'h8;

  // ------------------------------------------------------------
  // value after reset and timer maximum
  // ------------------------------------------------------------
  localparam logic [15:0] RST_TIMER = 16'h0000;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;
endpackage

//--- sim/dcc_sva.sv
// checker: handshake, reset, interrupt and pin-direction relations at the top ports
`timescale 1ns/100ps
module dcc_sva (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_ch_oe,
  input wire logic o_irq
);
  logic acc;
  logic wr_done;
  // ----
  // helpers
  // ----
  // a finished write is the only thing that may lower the interrupt or change pin direction
  assign acc = i_psel && i_penable;
  assign wr_done = acc && i_pwrite && o_pready;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn || !i_ce);
  // one wait state, then a single-cycle answer
  AST_PREADY_WAIT: assert property (acc && !o_pready && !$past(acc) |=> o_pready)
    else $error("pready not in second access cycle");
  AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (o_pready |-> acc && $past(acc))
    else $error("pready outside an access phase");
  AST_ERR_DATA: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
    else $error("pslverr without pready or with data");
  AST_UNMAPPED: assert property (o_pready && i_paddr >= 12'h220 |-> o_pslverr)
    else $error("unmapped address accepted");
  AST_MAPPED: assert property (o_pready && i_paddr == dcc_pkg::OFS_CH_EN |-> !o_pslverr)
    else $error("mapped address refused");
  AST_IRQ_HOLD: assert property ($fell(o_irq) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("interrupt dropped without a write");
  AST_OE_BY_WRITE: assert property ($changed(o_ch_oe) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("pin direction changed without a write");
  // reset must clear outputs, so this one ignores the default disable
  AST_RESET_OUT: assert property (disable iff (1'b0) !i_rstn && i_ce |=> !o_irq && !o_pready && o_ch_oe == 32'h0)
    else $error("outputs not cleared by reset");
  CV_ERR: cover property (o_pslverr);
  CV_IRQ: cover property ($rose(o_irq));
  CV_OE: cover property ($rose(o_ch_oe[2]));
endmodule
bind dcc_top dcc_sva u_dcc_sva (.*);

//--- sim/dcc_pin_model.sv
// far-side pin model: outside drivers meet the channel outputs on each wire
`timescale 1ns/100ps
module dcc_pin_model (
  input wire logic [31:0] i_ext,
  input wire logic [31:0] i_out,
  input wire logic [31:0] i_oe,
  output logic [31:0] o_level
);
  // a driving channel owns its wire; the outside drives it only while released
  assign o_level = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule

//--- sim/dcc_tb_top.sv
// testbench: register rows, compare modes, capture edges, interrupts, timer clocks
`timescale 1ns/100ps
module dcc_tb_top;
  logic i_sys_clk = 0, i_rstn = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_gpt_ovf = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, i_ch_pin, o_prdata, o_ch_pin, o_ch_oe, rd, ext = 32'h0;
  logic [1:0] i_ext_count = 2'h0;
  logic o_pready, o_pslverr, o_irq, er;
  int err_count = 0, checks = 0;
  logic [11:0] ra [6] = '{12'h010, 12'h0BC, 12'h1BC, 12'h200, 12'h3FC, 12'h208};
  logic [31:0] rw [6] = '{32'hFFFFFFFF, 32'h12345678, 32'hFFFFABCD, 32'hFFFFFFFF, 32'h1, 32'hFFFFFFFF};
  logic [31:0] rx [6] = '{32'hFFFF, 32'h5678, 32'hABCD, 32'h0, 32'h0, 32'hFFFFFFFF};
  logic re [6] = '{0, 0, 0, 0, 1, 0};
  logic [31:0] cv [4] = '{32'hFFFE, 32'hFFFE, 32'hFFFD, 32'hFFFE};
  logic [31:0] md [7] = '{32'h5, 32'h4, 32'h7, 32'h6, 32'h1, 32'h2, 32'h3};
  dcc_top u_dcc_top (.*);
  dcc_pin_model u_dcc_pin_model (.i_ext(ext), .i_out(o_ch_pin), .i_oe(o_ch_oe), .o_level(i_ch_pin));
  // ----
  // tasks
  // ----
  always #50 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // request held until pready is seen high; no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1 && ++n < 50);
    if (n >= 50) err_count++;
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // each pulse is one overflow of the general timer, so one exact tick
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      i_gpt_ovf <= 1'b1;
      @(posedge i_sys_clk);
      i_gpt_ovf <= 1'b0;
    end
    @(negedge i_sys_clk);
  endtask
  // each pulse is one rising edge on the external count input of timer a
  task automatic ext_pulse(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      i_ext_count[0] <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_ext_count[0] <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
    end
    @(negedge i_sys_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  // main run: rows first, then the hand-written cases
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(negedge i_sys_clk);
    chk(o_ch_oe, 32'h0);
    chk(o_irq, 1'b0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], rw[i]);
      rdchk(ra[i], rx[i]);
      chk(er, re[i]);
    end
    apb(1'b1, 12'h010, 32'hFFFC);
    apb(1'b1, 12'h008, 32'hFFFC);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 12'h040 + 12'(k * 4), md[k]);
      if (k < 4) apb(1'b1, 12'h080 + 12'(k * 4), cv[k]);
    end
    apb(1'b1, 12'h214, 32'h1);
    apb(1'b1, 12'h000, 32'h28);
    chk(o_ch_oe[6:4], 3'b000);
    tick(1);
    chk(o_ch_pin[2], 1'b1);
    tick(1);
    chk(o_ch_pin[0], 1'b1);
    rdchk(12'h200, 32'hF);
    // rewind inside the period: repeat matches allowed only for some modes
    apb(1'b1, 12'h204, 32'hF);
    apb(1'b1, 12'h008, 32'hFFFD);
    tick(1);
    rdchk(12'h200, 32'h3);
    chk({o_ch_pin[2], o_ch_pin[0]}, 2'b10);
    tick(2);
    chk(o_ch_pin[2], 1'b0);
    rdchk(12'h20C, 32'h1);
    rdchk(12'h008, 32'hFFFC);
    apb(1'b1, 12'h204, 32'hF);
    apb(1'b1, 12'h210, 32'hF);
    tick(2);
    rdchk(12'h200, 32'hF);
    apb(1'b1, 12'h204, 32'hF);
    @(posedge i_sys_clk);
    ext[6:4] <= 3'b111;
    rdchk(12'h200, 32'h50);
    rdchk(12'h090, 32'hFFFE);
    tick(1);
    @(posedge i_sys_clk);
    ext[6:4] <= 3'b000;
    rdchk(12'h200, 32'h70);
    rdchk(12'h094, 32'hFFFF);
    rdchk(12'h098, 32'hFFFF);
    chk(o_irq, 1'b1);
    apb(1'b1, 12'h208, 32'h0);
    repeat (2) @(negedge i_sys_clk);
    chk(o_irq, 1'b0);
    apb(1'b1, 12'h208, 32'hFFFFFFFF);
    repeat (2) @(negedge i_sys_clk);
    chk(o_irq, 1'b1);
    apb(1'b1, 12'h204, 32'hFFFFFFFF);
    apb(1'b1, 12'h210, 32'hF);
    repeat (2) @(negedge i_sys_clk);
    chk(o_irq, 1'b0);
    apb(1'b1, 12'h000, 32'h30);
    apb(1'b1, 12'h008, 32'h0);
    ext_pulse(3);
    rdchk(12'h008, 32'h3);
    // clock enable low: an external edge must leave the count alone
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    @(posedge i_sys_clk);
    i_ext_count[0] <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_ext_count[0] <= 1'b0;
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    rdchk(12'h008, 32'h3);
    // double register mode: channel 0 and its partner 8 toggle pin 0
    apb(1'b1, 12'h080, 32'h4);
    apb(1'b1, 12'h0A0, 32'h5);
    apb(1'b1, 12'h040, 32'h8);
    er = o_ch_pin[0];
    ext_pulse(1);
    chk(o_ch_pin[0], !er);
    ext_pulse(1);
    chk(o_ch_pin[0], er);
    rdchk(12'h200, 32'h101);
    // every divider code: ten periods should give about ten ticks
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h00C, 32'h0);
      apb(1'b1, 12'h004, 32'h20 | k);
      repeat (10 * (8 << k)) @(posedge i_sys_clk);
      apb(1'b0, 12'h00C, 32'h0);
      chk(32'(rd >= 9 && rd <= 11), 32'h1);
    end
    conclude();
  end
  // watchdog: the run needs about 2.1 ms
  initial begin
    #5_000_000;
    err_count++;
    conclude();
  end
endmodule
